// >>> hdl/sampler_payload_pkg.sv
// Constants and types shared by the sampler payload decoder files
package sampler_payload_pkg;

	// APB geometry
	localparam int          APB_AW      = 12;
	localparam int          APB_DW      = 32;

	// Register byte offsets
	localparam logic [11:0] OFS_CTRL    = 12'h000;
	localparam logic [11:0] OFS_SIZE0   = 12'h004;
	localparam logic [11:0] OFS_SIZE1   = 12'h008;
	localparam logic [11:0] OFS_STATUS  = 12'h00C;

	// Field positions
	localparam int          CTRL_CLASS_LSB = 0;
	localparam int          CTRL_SIMD_LSB  = 4;
	localparam int          CTRL_SURF_LSB  = 8;
	localparam int          CTRL_MEDIA_BIT = 12;
	localparam int          SIZE_LO_LSB    = 0;
	localparam int          SIZE_HI_LSB    = 16;
	localparam int          STAT_BUSY_BIT  = 0;
	localparam int          STAT_LEN_LSB   = 8;
	localparam int          STAT_ENT_LSB   = 16;

	// Reset values
	localparam logic [31:0] RST_CTRL    = 32'h0000_0000;
	localparam logic [31:0] RST_SIZE    = 32'h0001_0001;

	// Surface dimension width and payload geometry
	localparam int          SIZE_W      = 14;
	localparam int          DW_W        = 32;
	localparam int          REG_DWORDS  = 8;
	localparam int          REG_W       = DW_W * REG_DWORDS;

	// Numeric constants
	localparam logic [31:0] FLOAT_ONE   = 32'h3F80_0000;
	localparam logic [31:0] FI_U_MAX    = 32'h0000_0FFF;
	localparam logic [31:0] FI_V_MAX    = 32'h0000_07FE;

	// Block-sample dword positions (pixel shader and media layouts)
	localparam logic [2:0]  BLK_USTEP_PS  = 3'h0;
	localparam logic [2:0]  BLK_U2ND_PS   = 3'h1;
	localparam logic [2:0]  BLK_USTEP_MD  = 3'h1;
	localparam logic [2:0]  BLK_U2ND_MD   = 3'h0;
	localparam logic [2:0]  BLK_U0        = 3'h2;
	localparam logic [2:0]  BLK_VSTEP     = 3'h5;
	localparam logic [2:0]  BLK_V0        = 3'h6;

	typedef enum logic [2:0] {
		CL_FILTERED     = 3'b000,
		CL_LOD_QUERY    = 3'b001,
		CL_GATHER       = 3'b010,
		CL_TEXEL_FETCH  = 3'b011,
		CL_RESINFO      = 3'b100,
		CL_PACKED_BLOCK = 3'b101,
		CL_WIDE_BLOCK   = 3'b110,
		CL_FIELD_INTERP = 3'b111
	} msg_class_t;

	typedef enum logic [1:0] {
		SIMD16  = 2'b00,
		SIMD8   = 2'b01,
		SIMD4X2 = 2'b10,
		SIMD_BLOCK = 2'b11
	} simd_t;

	typedef enum logic [2:0] {
		ONE_DIM_SURFACE      = 3'b000,
		TWO_DIM_SURFACE      = 3'b001,
		THREE_DIM_SURFACE    = 3'b010,
		CUBE_SURFACE         = 3'b011,
		LINEAR_BUFFER_SURFACE = 3'b100
	} surf_t;

	typedef enum logic [1:0] {
		ST_COLLECT = 2'b00,
		ST_FETCH   = 2'b01,
		ST_LATCH   = 2'b10,
		ST_EMIT    = 2'b11
	} dec_state_t;

endpackage

// >>> hdl/sampler_payload_store.sv
// Message register store with one write port and a registered read port
`timescale 1ns/100ps
module sampler_payload_store #(
	parameter int WIDTH = 256,
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	input  wire logic             i_mclk,
	input  wire logic             i_sys_rst,
	input  wire logic             i_we,
	input  wire logic [AW-1:0]    i_waddr,
	input  wire logic [WIDTH-1:0] i_wdata,
	input  wire logic [AW-1:0]    i_raddr,
	output logic      [WIDTH-1:0] o_rdata
);

	logic [WIDTH-1:0] mem [DEPTH];

	// Array left unreset; only the read register needs a defined value
	always_ff @(posedge i_mclk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	// Read data leaves through a register
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_rdata <= '0;
		end else begin
			o_rdata <= mem[i_raddr];
		end
	end

endmodule // sampler_payload_store

// >>> hdl/sampler_input_payload_decoder.sv
// Sampler request payload decoder with APB configuration registers
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/100ps
//
// Operation
// R1: Filtered, lod_query and gather requests treat parameters as 32-bit floats.
// R2: Normalized coordinates span [0,1]; outside flagged for address control.
// R3: Unnormalized float indices span [0,n-1] and are clamped to surface.
// R4: Float coordinate slots assigned from u, v, r, index by surface type.
// R5: texel_fetch parameters are signed integers assigned per surface type.
// R6: texel_fetch coordinates outside zero to n-1 return zero.
// R7: SIMD16 parameter uses two registers of eight 32-bit entities each.
// R8: Requester keeps fixed positions; parameters past message length read zero.
// R9: SIMD16 first register subspans 0-1, second 2-3, four dwords each.
// R10: Dwords are float for filtered types, U32 for fetch and resinfo.
// R11: SIMD8 carries eight pixels, one register per parameter.
// R12: SIMD4x2 carries two samples, four parameters per register.
// R13: Pixel shader block layout: step, derivative, U0, V step, V0.
// R14: Media block layout swaps U step and U second derivative dwords.
// R15: Block U0/V0 are floats, except field interpolation U32 ranges.
// R16: Field interpolation ignores steps; derivative used only by wide block.
// R17: Requester bounds step times surface size for block requests.
module sampler_input_payload_decoder #(
	parameter int MSG_REGS = 16
) (
	input  wire logic                                     i_mclk,
	input  wire logic                                     i_sys_rst,
	input  wire logic                                     i_psel,
	input  wire logic                                     i_penable,
	input  wire logic                                     i_pwrite,
	input  wire logic [sampler_payload_pkg::APB_AW-1:0]   i_paddr,
	input  wire logic [sampler_payload_pkg::APB_DW-1:0]   i_pwdata,
	output logic                                          o_pready,
	output logic                                          o_pslverr,
	output logic      [sampler_payload_pkg::APB_DW-1:0]   o_prdata,
	input  wire logic                                     i_msg_valid,
	input  wire logic                                     i_msg_last,
	input  wire logic [sampler_payload_pkg::REG_W-1:0]    i_msg_data,
	output logic                                          o_msg_ready,
	output logic                                          o_ent_valid,
	output logic      [4:0]                               o_ent_index,
	output logic      [31:0]                              o_coord_x,
	output logic      [31:0]                              o_coord_y,
	output logic      [31:0]                              o_coord_z,
	output logic      [31:0]                              o_coord_ai,
	output logic                                          o_coord_is_int,
	output logic      [2:0]                               o_norm_outside,
	output logic                                          o_zero_return,
	output logic      [31:0]                              o_u_step,
	output logic      [31:0]                              o_v_step,
	output logic      [31:0]                              o_u_second_derivative
);
	import sampler_payload_pkg::*;

	localparam int AW = $clog2(MSG_REGS);

	// Unsigned integer to float, exact for 16-bit inputs
	function automatic logic [31:0] u_to_float(input logic [15:0] v);
		logic [4:0]  msb;
		logic [38:0] sh;
		msb = 5'h00;
		for (int i = 0; i < 16; i++) begin
			if (v[i]) begin
				msb = 5'(i);
			end
		end
		sh = {23'h000000, v} << (5'd23 - msb);
		if (v == 16'h0000) begin
			return 32'h0000_0000;
		end
		return {1'b0, 8'(8'd127 + {3'h0, msb}), sh[22:0]};
	endfunction

	// Unnormalized float index clamped to [0,n-1]
	function automatic logic [31:0] clamp_index(input logic [31:0] f,
			input logic [SIZE_W-1:0] n);
		logic [31:0] fmax;
		fmax = u_to_float(16'({2'b00, n} - 16'h0001));
		if (n == '0 || f[31]) begin
			return 32'h0000_0000; // [R3]
		end
		if (f[30:0] > fmax[30:0]) begin
			return fmax; // [R3]
		end
		return f;
	endfunction

	// Normalized float outside [0,1]; wrap/mirror/clamp is downstream
	function automatic logic norm_out(input logic [31:0] f);
		return (f[31] && f[30:0] != 31'h0) || (f[30:0] > FLOAT_ONE[30:0]);
	endfunction

	// Signed integer outside [0,n-1]
	function automatic logic int_out(input logic [31:0] v,
			input logic [SIZE_W-1:0] n);
		return v[31] || (v >= {{(32-SIZE_W){1'b0}}, n});
	endfunction

	// Register and dword holding parameter p of entity e
	function automatic logic [7:0] param_loc(input simd_t s,
			input logic [4:0] e, input logic [1:0] p);
		case (s)
			SIMD16:  return {5'({p, 1'b0}) + 5'(e[3]), e[2:0]}; // [R7] [R9]
			SIMD8:   return {5'(p), e[2:0]}; // [R11]
			SIMD4X2: return {5'h00, e[0], p}; // [R12]
			default: return 8'h00;
		endcase
	endfunction

	function automatic logic [4:0] ent_count(input simd_t s);
		case (s)
			SIMD16:  return 5'd16; // [R7]
			SIMD8:   return 5'd8; // [R11]
			SIMD4X2: return 5'd2; // [R12]
			default: return 5'd1;
		endcase
	endfunction

	// Configuration and APB state
	logic [31:0] ctrl, size0, size1, next_ctrl, next_size0, next_size1;
	logic        next_pready, next_pslverr;
	logic [31:0] next_prdata;

	// Decoder state
	dec_state_t        state, next_state;
	logic [AW:0]       msg_len, next_msg_len;
	logic [4:0]        ent, next_ent;
	logic [1:0]        pidx, next_pidx;
	logic [2:0]        dsel, next_dsel;
	logic              miss, next_miss;
	logic [31:0]       prm [4];
	logic [31:0]       next_prm [4];
	logic [31:0]       blk_v0, next_blk_v0;
	logic [REG_W-1:0]  rdata;
	logic [AW-1:0]     raddr;
	logic [7:0]        loc;
	logic              wr_en;

	msg_class_t        cls;
	simd_t             simd;
	surf_t             surf;
	logic [SIZE_W-1:0] s_w, s_h, s_d, s_a;

	assign cls  = msg_class_t'(ctrl[CTRL_CLASS_LSB +: 3]);
	assign simd = simd_t'(ctrl[CTRL_SIMD_LSB +: 2]);
	assign surf = surf_t'(ctrl[CTRL_SURF_LSB +: 3]);
	assign s_w  = size0[SIZE_LO_LSB +: SIZE_W];
	assign s_h  = size0[SIZE_HI_LSB +: SIZE_W];
	assign s_d  = size1[SIZE_LO_LSB +: SIZE_W];
	assign s_a  = size1[SIZE_HI_LSB +: SIZE_W];

	// One-wait-state APB slave; pready comes one cycle into the access phase
	always_comb begin
		next_ctrl    = ctrl;
		next_size0   = size0;
		next_size1   = size1;
		next_pready  = 1'b0;
		next_pslverr = 1'b0;
		next_prdata  = 32'h0000_0000;
		if (i_psel && i_penable && !o_pready) begin
			next_pready = 1'b1;
			case (i_paddr)
				OFS_CTRL:   next_prdata = ctrl;
				OFS_SIZE0:  next_prdata = size0;
				OFS_SIZE1:  next_prdata = size1;
				OFS_STATUS: begin
					next_prdata[STAT_BUSY_BIT] = (state != ST_COLLECT);
					next_prdata[STAT_LEN_LSB +: AW+1] = msg_len;
					next_prdata[STAT_ENT_LSB +: 5] = ent;
				end
				default:    next_pslverr = 1'b1;
			endcase
		end
		// Writes land on the completing edge only
		if (i_psel && i_penable && o_pready && i_pwrite) begin
			case (i_paddr)
				OFS_CTRL:  next_ctrl  = {19'h0, i_pwdata[12:0]};
				OFS_SIZE0: next_size0 = i_pwdata;
				OFS_SIZE1: next_size1 = i_pwdata;
				default:   next_ctrl  = ctrl;
			endcase
		end
	end

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ctrl      <= RST_CTRL;
			size0     <= RST_SIZE;
			size1     <= RST_SIZE;
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0000_0000;
		end else begin
			ctrl      <= next_ctrl;
			size0     <= next_size0;
			size1     <= next_size1;
			o_pready  <= next_pready;
			o_pslverr <= next_pslverr;
			o_prdata  <= next_prdata;
		end
	end

	// Registers beyond the store depth are dropped, not wrapped
	assign wr_en = i_msg_valid && o_msg_ready && (msg_len < (AW+1)'(MSG_REGS));
	assign loc   = param_loc(simd, ent, pidx);
	assign raddr = (state == ST_COLLECT) ? '0 : AW'(loc[7:3]);

	sampler_payload_store #(
		.WIDTH (REG_W),
		.DEPTH (MSG_REGS),
		.AW    (AW)
	) u_store (
		.i_mclk    (i_mclk),
		.i_sys_rst (i_sys_rst),
		.i_we      (wr_en),
		.i_waddr   (AW'(msg_len)),
		.i_wdata   (i_msg_data),
		.i_raddr   (raddr),
		.o_rdata   (rdata)
	);

	// Collect, then for each entity walk its parameters and emit it
	always_comb begin
		logic       media;
		logic       fi;
		next_state   = state;
		next_msg_len = msg_len;
		next_ent     = ent;
		next_pidx    = pidx;
		next_dsel    = dsel;
		next_miss    = miss;
		next_prm     = prm;
		next_blk_v0  = blk_v0;
		media        = ctrl[CTRL_MEDIA_BIT];
		fi           = (cls == CL_FIELD_INTERP);
		case (state)
			ST_COLLECT: begin
				if (wr_en) begin
					next_msg_len = msg_len + 1'b1;
				end
				if (i_msg_valid && i_msg_last) begin
					next_state = ST_FETCH;
					next_ent   = 5'h00;
					next_pidx  = 2'h0;
				end
			end
			ST_FETCH: begin
				next_dsel  = loc[2:0];
				next_miss  = ({1'b0, loc[7:3]} >= 6'(msg_len)); // [R8]
				next_state = ST_LATCH;
			end
			ST_LATCH: begin
				if (simd == SIMD_BLOCK) begin
					// Step and derivative dwords swap in the media layout
					next_prm[0] = rdata[32*(media ? BLK_USTEP_MD
						: BLK_USTEP_PS) +: 32]; // [R13] [R14]
					next_prm[1] = rdata[32*(media ? BLK_U2ND_MD
						: BLK_U2ND_PS) +: 32]; // [R13] [R14]
					next_prm[2] = rdata[32*BLK_U0 +: 32]; // [R13]
					next_prm[3] = rdata[32*BLK_VSTEP +: 32]; // [R13]
					next_blk_v0 = rdata[32*BLK_V0 +: 32]; // [R13]
					if (miss) begin
						next_prm[0] = 32'h0000_0000; // [R8]
						next_prm[1] = 32'h0000_0000;
						next_prm[2] = 32'h0000_0000;
						next_prm[3] = 32'h0000_0000;
						next_blk_v0 = 32'h0000_0000;
					end
					next_state = ST_EMIT;
				end else begin
					next_prm[pidx] = miss ? 32'h0000_0000
						: rdata[32*dsel +: 32]; // [R8]
					next_pidx  = pidx + 2'h1;
					next_state = (pidx == 2'h3) ? ST_EMIT : ST_FETCH;
				end
			end
			ST_EMIT: begin
				next_pidx = 2'h0;
				if (ent + 5'h01 >= ent_count(simd)) begin
					next_state   = ST_COLLECT;
					next_msg_len = '0;
				end else begin
					next_ent   = ent + 5'h01;
					next_state = ST_FETCH;
				end
			end
			default: next_state = ST_COLLECT;
		endcase
	end

	// Coordinate decode of the gathered parameters
	logic [31:0] dx, dy, dz, dai, dus, dvs, du2;
	logic        dint, dzero;
	logic [2:0]  dnorm;
	always_comb begin
		dx = prm[0];
		dy = 32'h0000_0000;
		dz = 32'h0000_0000;
		dai = 32'h0000_0000;
		dus = 32'h0000_0000;
		dvs = 32'h0000_0000;
		du2 = 32'h0000_0000;
		dint = (cls == CL_TEXEL_FETCH) || (cls == CL_RESINFO); // [R10]
		dzero = 1'b0;
		dnorm = 3'h0;
		case (cls)
			CL_TEXEL_FETCH: begin
				case (surf)
					ONE_DIM_SURFACE: begin
						dai   = prm[1]; // [R5]
						dzero = int_out(prm[0], s_w)
							|| int_out(prm[1], s_a); // [R6]
					end
					THREE_DIM_SURFACE: begin
						dy    = prm[1]; // [R5]
						dz    = prm[2];
						dzero = int_out(prm[0], s_w) || int_out(prm[1], s_h)
							|| int_out(prm[2], s_d); // [R6]
					end
					LINEAR_BUFFER_SURFACE: begin
						dzero = int_out(prm[0], s_w); // [R5] [R6]
					end
					default: begin
						dy    = prm[1]; // [R5]
						dai   = prm[2];
						dzero = int_out(prm[0], s_w) || int_out(prm[1], s_h)
							|| int_out(prm[2], s_a); // [R6]
					end
				endcase
				if (dzero) begin
					dx  = 32'h0000_0000; // [R6]
					dy  = 32'h0000_0000;
					dz  = 32'h0000_0000;
					dai = 32'h0000_0000;
				end
			end
			CL_RESINFO: begin
				dy  = prm[1]; // [R10]
				dz  = prm[2];
				dai = prm[3];
			end
			CL_PACKED_BLOCK, CL_WIDE_BLOCK, CL_FIELD_INTERP: begin
				dx  = prm[2]; // [R15]
				dy  = blk_v0;
				// Step bounds are the requester's duty, not checked
				dus = prm[0]; // [R17]
				dvs = prm[3]; // [R17]
				if (cls == CL_WIDE_BLOCK) begin
					du2 = prm[1]; // [R16]
				end
				if (cls == CL_FIELD_INTERP) begin
					dint = 1'b1; // [R15]
					dus  = 32'h0000_0000; // [R16]
					dvs  = 32'h0000_0000; // [R16]
					dx   = (prm[2] > FI_U_MAX) ? FI_U_MAX : prm[2]; // [R15]
					dy   = (blk_v0 > FI_V_MAX) ? FI_V_MAX : blk_v0; // [R15]
				end
			end
			default: begin
				// Float requests; parameter 0 is always normalized x
				dnorm[0] = norm_out(prm[0]); // [R1] [R2]
				case (surf)
					ONE_DIM_SURFACE: dai = clamp_index(prm[1], s_a); // [R4]
					TWO_DIM_SURFACE: begin
						dy       = prm[1]; // [R4]
						dai      = clamp_index(prm[2], s_a); // [R4] [R3]
						dnorm[1] = norm_out(prm[1]); // [R2]
					end
					THREE_DIM_SURFACE, CUBE_SURFACE: begin
						dy       = prm[1]; // [R4]
						dz       = prm[2];
						dnorm[1] = norm_out(prm[1]); // [R2]
						dnorm[2] = norm_out(prm[2]); // [R2]
						if (surf == CUBE_SURFACE) begin
							dai = clamp_index(prm[3], s_a); // [R4] [R3]
						end
					end
					default: dy = 32'h0000_0000;
				endcase
			end
		endcase
	end

	// State and output registers
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state <= ST_COLLECT;
			msg_len <= '0;
			ent <= 5'h00;
			pidx <= 2'h0;
			dsel <= 3'h0;
			miss <= 1'b0;
			prm <= '{default: 32'h0000_0000};
			blk_v0 <= 32'h0000_0000;
			o_msg_ready <= 1'b0;
			o_ent_valid <= 1'b0;
			o_ent_index <= 5'h00;
			o_coord_x <= 32'h0000_0000;
			o_coord_y <= 32'h0000_0000;
			o_coord_z <= 32'h0000_0000;
			o_coord_ai <= 32'h0000_0000;
			o_coord_is_int <= 1'b0;
			o_norm_outside <= 3'h0;
			o_zero_return <= 1'b0;
			o_u_step <= 32'h0000_0000;
			o_v_step <= 32'h0000_0000;
			o_u_second_derivative <= 32'h0000_0000;
		end else begin
			state <= next_state;
			msg_len <= next_msg_len;
			ent <= next_ent;
			pidx <= next_pidx;
			dsel <= next_dsel;
			miss <= next_miss;
			prm <= next_prm;
			blk_v0 <= next_blk_v0;
			o_msg_ready <= (next_state == ST_COLLECT);
			o_ent_valid <= (state == ST_EMIT);
			if (state == ST_EMIT) begin
				o_ent_index <= ent;
				o_coord_x <= dx;
				o_coord_y <= dy;
				o_coord_z <= dz;
				o_coord_ai <= dai;
				o_coord_is_int <= dint;
				o_norm_outside <= dnorm;
				o_zero_return <= dzero;
				o_u_step <= dus;
				o_v_step <= dvs;
				o_u_second_derivative <= du2;
			end
		end
	end

endmodule // sampler_input_payload_decoder

// >>> test/sampler_decoder_asserts.sv
// Port-level checks for the sampler payload decoder
`timescale 1ns/100ps
module sampler_decoder_checker #(
	parameter int MSG_REGS = 16
) (
	input wire logic        i_mclk,
	input wire logic        i_sys_rst,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic [11:0] i_paddr,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        i_msg_valid,
	input wire logic        i_msg_last,
	input wire logic        o_msg_ready,
	input wire logic        o_ent_valid,
	input wire logic [4:0]  o_ent_index,
	input wire logic [31:0] o_coord_x,
	input wire logic [31:0] o_coord_y,
	input wire logic [31:0] o_coord_z,
	input wire logic [31:0] o_coord_ai,
	input wire logic        o_coord_is_int,
	input wire logic [2:0]  o_norm_outside,
	input wire logic        o_zero_return,
	input wire logic [31:0] o_u_step,
	input wire logic [31:0] o_v_step,
	input wire logic [31:0] o_u_second_derivative
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_sys_rst);

	// Final register of a message taken at this edge
	wire msg_end = i_msg_valid && i_msg_last && o_msg_ready;

	// Bus answers after exactly one wait state, as a single pulse
	chk_pready_wait: assert property (i_psel && $rose(i_penable) |=> o_pready)
		else $error("pready not one cycle after access start");
	chk_pready_pulse: assert property (o_pready |=> !o_pready)
		else $error("pready longer than one cycle");
	chk_err_unmapped: assert property (o_pready && i_paddr > 12'h00C |-> o_pslverr)
		else $error("unmapped access without error");
	// Message intake closes, entities follow, intake reopens in bounds
	chk_ready_drop: assert property (msg_end |=> !o_msg_ready)
		else $error("intake still open after last register");
	chk_first_ent: assert property (msg_end |-> ##[2:16] o_ent_valid)
		else $error("no entity after message end");
	chk_ready_back: assert property (msg_end |-> ##[2:400] o_msg_ready)
		else $error("intake did not reopen");
	chk_ent_gap: assert property (o_ent_valid |=> !o_ent_valid [*2])
		else $error("entities closer than three cycles");
	chk_index_range: assert property (o_ent_valid |-> o_ent_index < 5'h10)
		else $error("entity index beyond sixteen");
	// Integer and zero-return outputs stay consistent
	chk_zero_coords: assert property (o_ent_valid && o_zero_return |->
		(o_coord_x | o_coord_y | o_coord_z | o_coord_ai) == 32'h0)
		else $error("zero return with nonzero coordinate");
	chk_float_nozero: assert property (o_ent_valid && !o_coord_is_int
		|-> !o_zero_return)
		else $error("zero return on float request");
	chk_int_inside: assert property (o_ent_valid && o_coord_is_int
		|-> o_norm_outside == 3'h0)
		else $error("outside flag on integer request");
	chk_int_steps: assert property (o_ent_valid && o_coord_is_int |->
		(o_u_step | o_v_step | o_u_second_derivative) == 32'h0)
		else $error("step field on integer request");
endmodule // sampler_decoder_checker

bind sampler_input_payload_decoder sampler_decoder_checker #(
	.MSG_REGS(MSG_REGS)) chk_i (.*);

// >>> test/shader_thread_model.sv
// Behavioural execution-unit thread that sends message registers
`timescale 1ns/100ps
module shader_thread_model (
	input  wire logic                             i_mclk,
	input  wire logic                             i_msg_ready,
	output logic                                  o_msg_valid,
	output logic                                  o_msg_last,
	output logic [sampler_payload_pkg::REG_W-1:0] o_msg_data
);
	import sampler_payload_pkg::*;

	// Idle at time zero; data shows a pattern rather than a stale word
	initial begin
		o_msg_valid = 1'b0;
		o_msg_last  = 1'b0;
		o_msg_data  = {REG_W{1'b1}};
	end

	// Registers go out whole, in order, none skipped; gap adds stalls
	task automatic send(input logic [REG_W-1:0] regs [16], input int n,
		input int gap);
		for (int k = 0; k < n; k++) begin
			o_msg_valid <= 1'b1;
			o_msg_last  <= (k == n - 1);
			o_msg_data  <= regs[k];
			do @(posedge i_mclk); while (i_msg_ready !== 1'b1);
			if (gap > 0 || k == n - 1) begin
				o_msg_valid <= 1'b0;
				o_msg_last  <= 1'b0;
				o_msg_data  <= ~regs[k]; // Released line shows inverse
				repeat (gap) @(posedge i_mclk);
			end
		end
	endtask
endmodule // shader_thread_model

// >>> test/test_sampler_input_payload_decoder.sv
// Self-checking bench for the sampler payload decoder
`timescale 1ns/100ps
module test_sampler_input_payload_decoder;
	import sampler_payload_pkg::*;
	localparam int W = 8; // Surface width and height used throughout
	logic              i_mclk, i_sys_rst, i_psel, i_penable, i_pwrite;
	logic [11:0]       i_paddr;
	logic [31:0]       i_pwdata, o_prdata;
	logic              o_pready, o_pslverr, i_msg_valid, i_msg_last;
	logic [REG_W-1:0]  i_msg_data;
	logic              o_msg_ready, o_ent_valid, o_coord_is_int;
	logic              o_zero_return;
	logic [4:0]        o_ent_index;
	logic [2:0]        o_norm_outside;
	logic [31:0]       o_coord_x, o_coord_y, o_coord_z, o_coord_ai;
	logic [31:0]       o_u_step, o_v_step, o_u_second_derivative;
	logic [REG_W-1:0]  msg [16];
	int                mismatches, tests_run, ents, cur_simd, cur_cls;
	int                nregs;
	logic              cur_media;

	sampler_input_payload_decoder #(.MSG_REGS(16))
		sampler_input_payload_decoder_i (.*);

	shader_thread_model shader_thread_model_i (.i_mclk(i_mclk),
		.i_msg_ready(o_msg_ready), .o_msg_valid(i_msg_valid),
		.o_msg_last(i_msg_last), .o_msg_data(i_msg_data));

	// 40 MHz clock
	initial begin
		i_mclk = 1'b0;
		forever #12.5 i_mclk = ~i_mclk;
	end

	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// Request held until pready is seen; the bench has the only timeout
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic er);
		i_psel <= 1'b1;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= wd;
		@(posedge i_mclk);
		i_penable <= 1'b1;
		do @(posedge i_mclk); while (o_pready !== 1'b1);
		rd = o_prdata;
		er = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_mclk); // Idle edge keeps calls from colliding
	endtask

	// Parameter p of entity e, zero past the message length
	function automatic logic [31:0] pv(input int e, input int p);
		int r, d;
		case (cur_simd)
			SIMD16: begin r = 2 * p + e / 8; d = e % 8; end
			SIMD8: begin r = p; d = e; end
			default: begin r = 0; d = 4 * e + p; end
		endcase
		return (r < nregs) ? msg[r][32 * d +: 32] : 32'h0;
	endfunction

	function automatic logic outf(input logic [31:0] f);
		return f[31] ? (f[30:0] != 31'h0) : (f[30:0] > 31'h3F80_0000);
	endfunction

	function automatic logic [31:0] gen();
		logic [31:0] ft [5] = '{32'h0, 32'h3F00_0000, 32'h3F80_0000,
			32'h4000_0000, 32'hBF00_0000};
		if (cur_cls == CL_TEXEL_FETCH) return 32'($urandom % 10) - 32'h1;
		if (cur_cls == CL_FILTERED) return ft[$urandom % 5];
		return 32'h3C00_0000 | ($urandom & 32'hFFFF); // Small steps
	endfunction

	// Compare each decoded entity with the payload it came from
	task automatic check_ent();
		logic [31:0] u, v;
		logic oob, f;
		u = pv(o_ent_index, 0);
		v = pv(o_ent_index, 1);
		f = (cur_cls == CL_FIELD_INTERP);
		oob = $signed(u) < 0 || $signed(u) >= W || $signed(v) < 0
			|| $signed(v) >= W;
		ents++;
		check("is_int", {31'h0, o_coord_is_int},
			{31'h0, f || cur_cls == CL_TEXEL_FETCH});
		if (cur_simd == SIMD_BLOCK) begin
			check("blk_x", o_coord_x, f ? FI_U_MAX : msg[0][95:64]);
			check("blk_y", o_coord_y, f ? FI_V_MAX : msg[0][223:192]);
			check("u_step", o_u_step, f ? 32'h0 : pv(0, cur_media));
			check("v_step", o_v_step, f ? 32'h0 : msg[0][191:160]);
			check("u_2nd", o_u_second_derivative, (cur_cls == CL_WIDE_BLOCK)
				? pv(0, !cur_media) : 32'h0);
		end else if (cur_cls == CL_TEXEL_FETCH) begin
			check("zero_return", {31'h0, o_zero_return}, {31'h0, oob});
			check("coord_x", o_coord_x, oob ? 32'h0 : u);
			check("coord_y", o_coord_y, oob ? 32'h0 : v);
		end else begin
			check("coord_x", o_coord_x, u);
			check("coord_y", o_coord_y, v);
			check("outside", {30'h0, o_norm_outside[1:0]},
				{30'h0, outf(v), outf(u)});
			check("coord_ai", o_coord_ai, 32'h0);
		end
	endtask

	always @(posedge i_mclk) if (o_ent_valid === 1'b1) check_ent();

	// Configure, send one message, wait for intake to reopen
	task automatic run_msg(input int simd, input int cls, input int n,
		input int nent, input logic media);
		logic [31:0] rd;
		logic er;
		cur_simd = simd;
		cur_cls = cls;
		nregs = n;
		cur_media = media;
		apb(1'b1, OFS_CTRL, 32'((cls << CTRL_CLASS_LSB) | (simd << CTRL_SIMD_LSB)
			| (int'(TWO_DIM_SURFACE) << CTRL_SURF_LSB)
			| (int'(media) << CTRL_MEDIA_BIT)), rd, er);
		for (int k = 0; k < 16; k++)
			for (int d = 0; d < 8; d++) msg[k][32 * d +: 32] = gen();
		if (simd == SIMD4X2) begin
			msg[0][127:64] = '0; // Array index slots kept in range
			msg[0][255:192] = '0;
		end
		ents = 0;
		shader_thread_model_i.send(msg, n, $urandom % 3);
		do @(posedge i_mclk); while (o_msg_ready !== 1'b1);
		repeat (2) @(posedge i_mclk);
		check("entities", ents, nent);
	endtask

	// Cuts a hang; the whole run needs somewhat over a thousand cycles
	initial begin
		repeat (40000) @(posedge i_mclk);
		mismatches++;
		stop_test();
	end

	// Main sequence: registers, then fetch on SIMD16, SIMD8 and SIMD4X2, filtered on SIMD8 only, and each block class in both block layouts
	initial begin
		logic [31:0] rd;
		logic er;
		{i_sys_rst, i_psel, i_penable, i_pwrite} = 4'hF & 4'h8;
		i_paddr = 12'h000;
		i_pwdata = 32'h0;
		void'($urandom(32'hCD1F5AA7));
		repeat (20) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		repeat (2) @(posedge i_mclk);
		apb(1'b0, OFS_CTRL, 32'h0, rd, er);
		check("ctrl_reset", rd, RST_CTRL);
		apb(1'b0, OFS_SIZE1, 32'h0, rd, er);
		check("size1_reset", rd, RST_SIZE);
		apb(1'b1, 12'h010, 32'hFFFF_FFFF, rd, er);
		check("wr_err", {31'h0, er}, 32'h1);
		apb(1'b0, 12'h010, 32'h0, rd, er);
		check("rd_unmapped", rd ^ {31'h0, ~er}, 32'h0);
		apb(1'b1, OFS_SIZE0, 32'h0008_0008, rd, er);
		apb(1'b0, OFS_SIZE0, 32'h0, rd, er);
		check("size0", rd, 32'h0008_0008);
		for (int i = 0; i < 3; i++) begin
			run_msg(SIMD16, CL_TEXEL_FETCH, 4, 16, 1'b0);
			run_msg(SIMD8, CL_TEXEL_FETCH, 2, 8, 1'b0);
			run_msg(SIMD4X2, CL_TEXEL_FETCH, 1, 2, 1'b0);
			run_msg(SIMD8, CL_FILTERED, 2, 8, 1'b0);
		end
		for (int c = CL_PACKED_BLOCK; c <= CL_FIELD_INTERP; c++) begin
			run_msg(SIMD_BLOCK, c, 1, 1, 1'b0);
			run_msg(SIMD_BLOCK, c, 1, 1, 1'b1);
		end
		stop_test();
	end
endmodule // test_sampler_input_payload_decoder
